// [common/prb_map.svh]
// constants for the management register bank: addresses, field positions, defaults
// assumes inclusion by bare name from the package and the bank module
`ifndef PRB_MAP_SVH
`define PRB_MAP_SVH

// base register numbers (page 0, except the page register, which decodes on every page)
`define PRB_REG_CTRL      5'h00
`define PRB_REG_STAT      5'h01
`define PRB_REG_IND_CTL   5'h0D
`define PRB_REG_IND_DAT   5'h0E
`define PRB_REG_EVT       5'h13
`define PRB_REG_CFG       5'h14
`define PRB_REG_AUX       5'h15
`define PRB_REG_PAGE      5'h16
`define PRB_PAGE_BASE     8'h00

// field positions
`define PRB_CTRL_SWRST    15
`define PRB_CTRL_MODE_HI  13
`define PRB_CTRL_MODE_LO  12
`define PRB_STAT_FAULT    4
`define PRB_STAT_LINK     2
`define PRB_AUX_ROS       0

// reset values
`define PRB_RWS_DEF       8'hA5
`define PRB_MODE_DEF      2'h0

// management opcodes as carried by the frame
`define PRB_OP_ADDR       2'h0
`define PRB_OP_WR         2'h1
`define PRB_OP_RD         2'h2
`define PRB_OP_RDI        2'h2
`define PRB_OP_C45_RD     2'h3

// indirect function codes in register 13
`define PRB_FN_ADDR       2'h0
`define PRB_FN_DATA       2'h1
`define PRB_FN_INC_RW     2'h2
`define PRB_FN_INC_WR     2'h3

// extended space that mirrors the paged base registers
`define PRB_EXT_DEV       5'h03
`define PRB_EXT_PREFIX    3'h4

// reference select strap codes
`define PRB_STRAP_25_XTAL 2'h3
`define PRB_STRAP_25_DIFF 2'h2
`define PRB_STRAP_125     2'h1
`define PRB_STRAP_156     2'h0

`endif

// [common/prb_pkg.sv]
// types shared by the management register bank
// assumes prb_map.svh on the include path
package prb_pkg;
    `include "prb_map.svh"

    typedef enum logic [1:0] {
        PRB_REF_25_XTAL,
        PRB_REF_25_DIFF,
        PRB_REF_125,
        PRB_REF_156
    } prb_ref_t;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_CTRL,
        SEL_STAT,
        SEL_IND_CTL,
        SEL_IND_DAT,
        SEL_EVT,
        SEL_CFG,
        SEL_AUX,
        SEL_PAGE
    } prb_sel_t;
endpackage

// [logic/prb_bank.sv]
// management register bank of one transceiver port: paging, indirect and
// extended access, field access types, reference clock strap decode
// assumes a frame decoder on sys_clk that pulses acc_valid once per completed frame
`timescale 1ns/1ps
`include "prb_map.svh"
module prb_bank
    import prb_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [1:0]       clk_sel_pin,
    input  wire logic             acc_valid,
    input  wire logic             acc_ext,
    input  wire logic [1:0]       acc_op,
    input  wire logic [4:0]       acc_dev,
    input  wire logic [4:0]       acc_reg,
    input  wire logic [15:0]      acc_wdata,
    input  wire logic             link_in,
    input  wire logic             fault_in,
    input  wire logic [7:0]       event_in,
    output logic                  acc_ack,
    output logic [15:0]           rd_data_q,
    output prb_pkg::prb_ref_t     ref_freq_q,
    output logic [7:0]            page_q,
    output logic [1:0]            ign_q,
    output logic [1:0]            mode_eff_q,
    output logic [7:0]            rwr_q,
    output logic [7:0]            rws_q,
    output logic                  swrst_q,
    output logic                  wo_stb_q,
    output logic [7:0]            wo_data_q
);
    import prb_pkg::*;

    function automatic prb_sel_t reg_sel(input logic [7:0] pg, input logic [4:0] rg);
        prb_sel_t s;
        s = SEL_NONE;
        if (rg == `PRB_REG_PAGE) begin
            s = SEL_PAGE;
        end else if (pg == `PRB_PAGE_BASE) begin
            case (rg)
                `PRB_REG_CTRL:    s = SEL_CTRL;
                `PRB_REG_STAT:    s = SEL_STAT;
                `PRB_REG_IND_CTL: s = SEL_IND_CTL;
                `PRB_REG_IND_DAT: s = SEL_IND_DAT;
                `PRB_REG_EVT:     s = SEL_EVT;
                `PRB_REG_CFG:     s = SEL_CFG;
                `PRB_REG_AUX:     s = SEL_AUX;
                default:          s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // returns {hit, page, reg}
    function automatic logic [13:0] map_ext(input logic [4:0] dv, input logic [15:0] ad);
        logic hit;
        hit = (dv == `PRB_EXT_DEV) && (ad[15:13] == `PRB_EXT_PREFIX);
        return {hit, ad[12:0]};
    endfunction

    logic [1:0]  s1_q, s2_q, s3_q, strap_q, strap_d;
    prb_ref_t    ref_d;
    logic        ack_d, swrst_d, ros_q, ros_d, lh_q, lh_d, ll_q, ll_d, wo_stb_d;
    logic [15:0] rd_d, c45_addr_q, c45_addr_d, ind_addr_q, ind_addr_d;
    logic [7:0]  page_d, rwr_d, rws_d, roc_q, roc_d, wo_data_d;
    logic [1:0]  ign_d, mode_new_q, mode_new_d, mode_eff_d, ind_fn_q, ind_fn_d;
    logic [4:0]  ind_dev_q, ind_dev_d;
    logic [13:0] m;
    logic [7:0]  t_page;
    logic [4:0]  t_reg;
    logic        t_rd, t_wr;
    prb_sel_t    sel;
    logic [15:0] rval;

    // strap: three stages, a change counts once stages two and three agree
    always_comb begin
        strap_d = (s2_q == s3_q) ? s3_q : strap_q;
        case (strap_q)
            `PRB_STRAP_25_XTAL: ref_d = PRB_REF_25_XTAL;
            `PRB_STRAP_25_DIFF: ref_d = PRB_REF_25_DIFF;
            `PRB_STRAP_125:     ref_d = PRB_REF_125;
            default:            ref_d = PRB_REF_156;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {s1_q, s2_q, s3_q, strap_q} <= 8'h00;
            ref_freq_q <= PRB_REF_156;
        end else begin
            {s1_q, s2_q, s3_q} <= {clk_sel_pin, s1_q, s2_q};
            strap_q    <= strap_d;
            ref_freq_q <= ref_d;
        end
    end

    always_comb begin
        ack_d = acc_valid;
        wo_stb_d = 1'b0;
        {rd_d, page_d, ign_d, swrst_d} = {rd_data_q, page_q, ign_q, swrst_q};
        {mode_new_d, mode_eff_d, rwr_d, rws_d} = {mode_new_q, mode_eff_q, rwr_q, rws_q};
        {ros_d, wo_data_d} = {ros_q, wo_data_q};
        {c45_addr_d, ind_addr_d} = {c45_addr_q, ind_addr_q};
        {ind_fn_d, ind_dev_d} = {ind_fn_q, ind_dev_q};
        // status capture runs every cycle; a set beats a clear by read
        lh_d = lh_q | fault_in;
        ll_d = ll_q & link_in;
        roc_d = roc_q | event_in;
        m = 14'h0000;
        t_page = page_q;
        t_reg = acc_reg;
        {t_rd, t_wr} = 2'b00;
        if (acc_valid && !acc_ext) begin
            t_rd = (acc_op == `PRB_OP_RD);
            t_wr = (acc_op == `PRB_OP_WR);
            // data port of the indirect pair redirects into extended space
            if (reg_sel(page_q, acc_reg) == SEL_IND_DAT && ind_fn_q != `PRB_FN_ADDR) begin
                m = map_ext(ind_dev_q, ind_addr_q);
                t_page = m[12:5];
                t_reg = m[4:0];
                if (!m[13]) begin
                    t_rd = 1'b0;
                    t_wr = 1'b0;
                end
                if (ind_fn_q == `PRB_FN_INC_RW || (ind_fn_q == `PRB_FN_INC_WR && t_wr)) begin
                    ind_addr_d = ind_addr_q + 16'h0001;
                end
            end
        end else if (acc_valid) begin
            if (acc_op == `PRB_OP_ADDR) begin
                c45_addr_d = acc_wdata;
            end else begin
                m = map_ext(acc_dev, c45_addr_q);
                t_page = m[12:5];
                t_reg = m[4:0];
                t_wr = m[13] && (acc_op == `PRB_OP_WR);
                t_rd = m[13] && (acc_op != `PRB_OP_WR);
                if (acc_op == `PRB_OP_RDI) begin
                    c45_addr_d = c45_addr_q + 16'h0001;
                end
            end
        end
        sel = reg_sel(t_page, t_reg);
        // indirect pair must not reach itself through the mirror
        if (m[13] && (sel == SEL_IND_CTL || sel == SEL_IND_DAT)) begin
            sel = SEL_NONE;
        end
        // unlisted bit positions read zero
        case (sel)
            SEL_CTRL:    rval = {swrst_q, 1'b0, mode_new_q, 12'h000};
            SEL_STAT:    rval = {6'h00, strap_q, 3'h0, lh_q, 1'b0, ll_q, 2'h0};
            SEL_IND_CTL: rval = {ind_fn_q, 9'h000, ind_dev_q};
            SEL_IND_DAT: rval = ind_addr_q;
            SEL_EVT:     rval = {8'h00, roc_q};
            SEL_CFG:     rval = {rws_q, rwr_q};
            SEL_AUX:     rval = {15'h0000, ros_q}; // write-only byte reads zero
            SEL_PAGE:    rval = {ign_q, 6'h00, page_q};
            default:     rval = 16'h0000;
        endcase
        if (t_rd) begin
            // data is taken from the old value; side effects land on the same edge
            rd_d = rval;
            case (sel)
                SEL_STAT: begin
                    lh_d = fault_in;
                    ll_d = link_in;
                end
                SEL_EVT:  roc_d = event_in;
                SEL_AUX:  ros_d = 1'b1;
                default:  ;
            endcase
        end
        if (t_wr) begin
            case (sel)
                SEL_CTRL: begin
                    swrst_d = acc_wdata[`PRB_CTRL_SWRST];
                    mode_new_d = acc_wdata[`PRB_CTRL_MODE_HI:`PRB_CTRL_MODE_LO];
                end
                SEL_IND_CTL: begin
                    ind_fn_d = acc_wdata[15:14];
                    ind_dev_d = acc_wdata[4:0];
                end
                SEL_IND_DAT: ind_addr_d = acc_wdata;
                SEL_CFG: begin
                    rwr_d = acc_wdata[7:0];
                    rws_d = acc_wdata[15:8];
                end
                SEL_AUX: begin
                    wo_stb_d = 1'b1;
                    wo_data_d = acc_wdata[15:8];
                end
                SEL_PAGE: begin
                    page_d = acc_wdata[7:0];
                    ign_d = acc_wdata[15:14];
                end
                default: ;
            endcase
        end
        // soft reset lasts one cycle; page and ignore bits are kept
        if (swrst_q) begin
            swrst_d = 1'b0;
            mode_eff_d = mode_new_q;
            rwr_d = 8'h00;
            rws_d = `PRB_RWS_DEF;
            ros_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {acc_ack, swrst_q, ros_q, lh_q, ll_q, wo_stb_q} <= 6'h00;
            {rd_data_q, c45_addr_q, ind_addr_q} <= 48'h0000_0000_0000;
            {page_q, rwr_q, roc_q, wo_data_q} <= 32'h0000_0000;
            {ign_q, ind_fn_q, ind_dev_q} <= 9'h000;
            mode_new_q <= `PRB_MODE_DEF;
            mode_eff_q <= `PRB_MODE_DEF;
            rws_q      <= `PRB_RWS_DEF;
        end else begin
            acc_ack    <= ack_d;
            rd_data_q  <= rd_d;
            page_q     <= page_d;
            ign_q      <= ign_d;
            swrst_q    <= swrst_d;
            mode_new_q <= mode_new_d;
            mode_eff_q <= mode_eff_d;
            rwr_q      <= rwr_d;
            rws_q      <= rws_d;
            ros_q      <= ros_d;
            lh_q       <= lh_d;
            ll_q       <= ll_d;
            roc_q      <= roc_d;
            wo_stb_q   <= wo_stb_d;
            wo_data_q  <= wo_data_d;
            c45_addr_q <= c45_addr_d;
            ind_addr_q <= ind_addr_d;
            ind_fn_q   <= ind_fn_d;
            ind_dev_q  <= ind_dev_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    strap_decode_a: assert property ((strap_q == `PRB_STRAP_125)
        |=> ref_freq_q == PRB_REF_125) else $error("strap decode wrong");
    roc_clear_a: assert property ((t_rd && sel == SEL_EVT && event_in == 8'h00)
        |=> roc_q == 8'h00) else $error("read-clear field not cleared");
    latch_high_a: assert property (fault_in |=> lh_q)
        else $error("latch high lost");
    latch_low_a: assert property (!link_in |=> !ll_q)
        else $error("latch low lost");
    retain_page_a: assert property ((swrst_q && !acc_valid)
        |=> $stable(page_q) && $stable(ign_q)) else $error("page changed by soft reset");
    rw_reset_a: assert property ((swrst_q && !acc_valid)
        |=> rwr_q == 8'h00 && rws_q == `PRB_RWS_DEF) else $error("rw defaults not loaded");
    read_sets_a: assert property ((t_rd && sel == SEL_AUX) |=> ros_q)
        else $error("read-sets field not set");
    self_clear_a: assert property (swrst_q |=> !swrst_q)
        else $error("self-clearing bit stuck");
    update_hold_a: assert property (!swrst_q |=> $stable(mode_eff_q))
        else $error("update field acted early");
    page_write_a: assert property ((acc_valid && !acc_ext && acc_op == `PRB_OP_WR
        && acc_reg == `PRB_REG_PAGE && ind_fn_q == `PRB_FN_ADDR)
        |=> page_q == $past(acc_wdata[7:0]))
        else $error("page register missed");
    read_ack_a: assert property (acc_valid
        |=> acc_ack ##1 !acc_ack || $past(acc_valid))
        else $error("ack not one cycle after frame");

    soft_reset_c: cover property (swrst_q ##1 !swrst_q);
    ext_read_c: cover property (acc_valid && acc_ext && t_rd);
    ind_write_c: cover property (m[13] && t_wr && !acc_ext);
    roc_read_c: cover property (t_rd && sel == SEL_EVT && roc_q != 8'h00);
endmodule // prb_bank

// [sim/prb_bank_tb.sv]
// self-checking bench for the management register bank
// assumes the station model drives the access port, bench drives status and straps
`timescale 1ns/1ps
module prb_bank_tb;
    import prb_pkg::*;

    logic              sys_clk;
    logic              reset_n;
    logic [1:0]        clk_sel_pin;
    logic              acc_valid;
    logic              acc_ext;
    logic [1:0]        acc_op;
    logic [4:0]        acc_dev;
    logic [4:0]        acc_reg;
    logic [15:0]       acc_wdata;
    logic              link_in;
    logic              fault_in;
    logic [7:0]        event_in;
    logic              acc_ack;
    logic [15:0]       rd_data_q;
    prb_pkg::prb_ref_t ref_freq_q;
    logic [7:0]        page_q;
    logic [1:0]        ign_q;
    logic [1:0]        mode_eff_q;
    logic [7:0]        rwr_q;
    logic [7:0]        rws_q;
    logic              swrst_q;
    logic              wo_stb_q;
    logic [7:0]        wo_data_q;
    logic [15:0]       rdv;
    int                fails;
    int                cmp_count;

    prb_bank dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_sel_pin(clk_sel_pin),
        .acc_valid(acc_valid), .acc_ext(acc_ext), .acc_op(acc_op), .acc_dev(acc_dev),
        .acc_reg(acc_reg), .acc_wdata(acc_wdata), .link_in(link_in),
        .fault_in(fault_in), .event_in(event_in), .acc_ack(acc_ack),
        .rd_data_q(rd_data_q), .ref_freq_q(ref_freq_q), .page_q(page_q), .ign_q(ign_q),
        .mode_eff_q(mode_eff_q), .rwr_q(rwr_q), .rws_q(rws_q), .swrst_q(swrst_q),
        .wo_stb_q(wo_stb_q), .wo_data_q(wo_data_q));

    prb_mgmt_stn stn_u (.sys_clk(sys_clk), .acc_ack(acc_ack), .rd_data_q(rd_data_q),
        .acc_valid(acc_valid), .acc_ext(acc_ext), .acc_op(acc_op), .acc_dev(acc_dev),
        .acc_reg(acc_reg), .acc_wdata(acc_wdata));

    always #5 sys_clk = ~sys_clk;

    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a missing ack ends the run instead of hanging on stale data
    task automatic acc(input logic ext, input logic [1:0] op, input logic [4:0] dev,
                       input logic [4:0] rg, input logic [15:0] wd);
        logic ok;
        stn_u.xfer(ext, op, dev, rg, wd, rdv, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: no acknowledge", $time);
            conclude();
        end
    endtask

    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        acc(1'b0, 2'h1, 5'h00, rg, d);
    endtask

    task automatic rd(input logic [4:0] rg);
        acc(1'b0, 2'h2, 5'h00, rg, 16'h0000);
    endtask

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        clk_sel_pin = 2'h0;
        link_in = 1'b1;
        fault_in = 1'b0;
        event_in = 8'h00;
        fails = 0;
        cmp_count = 0;
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        chk({rwr_q, rws_q}, 16'h00A5);
        chk({6'h00, mode_eff_q, page_q}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            clk_sel_pin = 2'(i);
            repeat (6) @(negedge sys_clk);
            chk(16'(ref_freq_q), 16'(3 - i));
        end
        clk_sel_pin = 2'h1;
        wr(5'h14, 16'h5A3C);
        chk({rws_q, rwr_q}, 16'h5A3C);
        wr(5'h16, 16'hFF05);
        chk({6'h00, ign_q, page_q}, 16'h0305);
        rd(5'h16);
        chk(rdv, 16'hC005);
        rd(5'h14);
        chk(rdv, 16'h0000);
        rd(5'h16);
        wr(5'h16, {rdv[15:14], 14'h0000});
        rd(5'h14);
        chk(rdv, 16'h5A3C);
        wr(5'h00, 16'h2000);
        chk(16'(mode_eff_q), 16'h0000);
        wr(5'h00, 16'hA000);
        chk(16'(swrst_q), 16'h0001);
        @(negedge sys_clk);
        chk(16'(swrst_q), 16'h0000);
        chk({6'h00, mode_eff_q, rwr_q}, 16'h0200);
        chk({6'h00, ign_q, rws_q}, 16'h03A5);
        // first read arms the latch-low bit so the link drop below can clear it
        rd(5'h01);
        chk(rdv & 16'h0014, 16'h0000);
        fault_in = 1'b1;
        link_in = 1'b0;
        event_in = 8'h81;
        @(negedge sys_clk);
        fault_in = 1'b0;
        link_in = 1'b1;
        event_in = 8'h00;
        rd(5'h01);
        chk(rdv & 16'h0014, 16'h0010);
        rd(5'h01);
        chk(rdv & 16'h0014, 16'h0004);
        rd(5'h13);
        chk(rdv, 16'h0081);
        rd(5'h13);
        chk(rdv, 16'h0000);
        rd(5'h15);
        chk(rdv & 16'h0001, 16'h0000);
        rd(5'h15);
        chk(rdv & 16'h0001, 16'h0001);
        wr(5'h15, 16'hB700);
        chk({7'h00, wo_stb_q, wo_data_q}, 16'h01B7);
        acc(1'b1, 2'h0, 5'h03, 5'h00, 16'h8014);
        acc(1'b1, 2'h1, 5'h03, 5'h00, 16'h1234);
        rd(5'h14);
        chk(rdv, 16'h1234);
        acc(1'b1, 2'h2, 5'h03, 5'h00, 16'h0000);
        chk(rdv, 16'h1234);
        acc(1'b1, 2'h3, 5'h03, 5'h00, 16'h0000);
        chk(rdv, 16'h0001);
        // wrong device must not reach the write-only byte at the same address
        acc(1'b1, 2'h1, 5'h05, 5'h00, 16'hFF00);
        chk({7'h00, wo_stb_q, wo_data_q}, 16'h00B7);
        wr(5'h0D, 16'h0003);
        wr(5'h0E, 16'h8014);
        wr(5'h0D, 16'h4003);
        rd(5'h0E);
        chk(rdv, 16'h1234);
        wr(5'h0D, 16'h8003);
        rd(5'h0E);
        chk(rdv, 16'h1234);
        rd(5'h0E);
        chk(rdv, 16'h0001);
        // hardware reset in mid-run restores what soft reset keeps
        wr(5'h16, 16'hC007);
        reset_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        chk({6'h00, ign_q, page_q}, 16'h0000);
        chk({rws_q, rwr_q}, 16'hA500);
        repeat (6) @(negedge sys_clk);
        chk(16'(ref_freq_q), 16'(PRB_REF_125));
        conclude();
    end
endmodule // prb_bank_tb

// [sim/prb_mgmt_stn.sv]
// management station model: one access frame per call on the bank's access port
// assumes the bank acknowledges exactly one cycle after taking a frame
`timescale 1ns/1ps
module prb_mgmt_stn (
    input  wire logic        sys_clk,
    input  wire logic        acc_ack,
    input  wire logic [15:0] rd_data_q,
    output logic             acc_valid,
    output logic             acc_ext,
    output logic [1:0]       acc_op,
    output logic [4:0]       acc_dev,
    output logic [4:0]       acc_reg,
    output logic [15:0]      acc_wdata
);
    import prb_pkg::*;

    initial begin
        acc_valid = 1'b0;
        acc_ext = 1'b0;
        acc_op = 2'h0;
        acc_dev = 5'h00;
        acc_reg = 5'h00;
        acc_wdata = 16'h0000;
    end

    // frame lasts one cycle; ok is low if the ack is not there one cycle later
    task automatic xfer(input logic ext, input logic [1:0] op, input logic [4:0] dev,
                        input logic [4:0] rg, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_ext = ext;
        acc_op = op;
        acc_dev = dev;
        acc_reg = rg;
        acc_wdata = wd;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        // idle data, register and device lines carry junk (op and ext keep their values), so a bank that samples late is caught
        acc_wdata = ~wd;
        acc_reg = ~rg;
        acc_dev = ~dev;
        ok = acc_ack;
        rd = rd_data_q;
    endtask
endmodule // prb_mgmt_stn
